/* design/sdrbb_pkg.sv */
// package: sdram bank burst access constants and types
package sdrbb_pkg;
  localparam int unsigned BANK_W     = 2;
  localparam int unsigned BANKS      = 4;
  localparam int unsigned ROW_W      = 13;
  localparam int unsigned COL_W      = 10;
  localparam int unsigned DQ_W       = 8;
  localparam int unsigned ROWS       = 8192;
  localparam int unsigned COLS       = 1024;
  localparam int unsigned AP_BIT     = 10;
  localparam int unsigned MEM_ROWS_W = 4;
  // cas latency in clocks and self-timed precharge delay
  localparam logic [1:0] CAS_LAT     = 2'h2;
  localparam logic [2:0] PRE_CYC     = 3'h3;
  localparam logic [1:0] DQM_LAT     = 2'h2;
  localparam logic [3:0] REF_CYC     = 4'h7;
  localparam int unsigned FULL_PAGE_SPAN = 1024;
  localparam int unsigned CMD_W      = 3;
  localparam int unsigned REFRESH_MS_STD = 64;
  localparam int unsigned REFRESH_MS_EXT = 16;

  // {ras_n, cas_n, we_n}
  localparam logic [2:0] CMD_NOP  = 3'h7;
  localparam logic [2:0] CMD_ACT  = 3'h3;
  localparam logic [2:0] CMD_RD   = 3'h5;
  localparam logic [2:0] CMD_WR   = 3'h4;
  localparam logic [2:0] CMD_BST  = 3'h6;
  localparam logic [2:0] CMD_PRE  = 3'h2;
  localparam logic [2:0] CMD_REF  = 3'h1;
  localparam logic [2:0] CMD_LMR  = 3'h0;

  // burst span codes
  typedef enum logic [2:0] {
    SDRBB_BL1  = 3'h0,
    SDRBB_BL2  = 3'h1,
    SDRBB_BL4  = 3'h2,
    SDRBB_BL8  = 3'h3,
    SDRBB_PAGE = 3'h7
  } sdrbb_span_t;
endpackage

/* design/sdrbb_if.sv */
// interface: sdram command, address and data pins between controller and memory
`timescale 1ns/10ps
interface sdrbb_if;
  import sdrbb_pkg::*;
  logic                 cs_n;
  logic                 ras_n;
  logic                 cas_n;
  logic                 we_n;
  logic [BANK_W-1:0]    ba;
  logic [ROW_W-1:0]     addr;
  logic                 dqm;
  logic [DQ_W-1:0]      dq_ctl_o;
  logic                 dq_ctl_oe;
  logic [DQ_W-1:0]      dq_mem_o;
  logic                 dq_mem_oe;
  logic                 power_down;
  wire  [DQ_W-1:0]      dq;
  assign dq = dq_mem_oe ? dq_mem_o : dq_ctl_o;

  modport mem (
    input  cs_n, ras_n, cas_n, we_n, ba, addr, dqm, dq_ctl_o, dq_ctl_oe, power_down,
    output dq_mem_o, dq_mem_oe
  );
  modport ctl (
    output cs_n, ras_n, cas_n, we_n, ba, addr, dqm, dq_ctl_o, dq_ctl_oe, power_down,
    input  dq_mem_o, dq_mem_oe
  );
endinterface

/* design/sdrbb_mem.sv */
// memory end: quad bank sdram core with bursts and auto precharge
// Contract
// - all inputs sampled on rising clock edge
// - four independent separately addressable banks
// - 8192 rows, columns per width
// - controller opens row before read/write
// - active: bank lines and row address
// - read/write address is starting column
// - burst walks columns internally, programmed order
// - burst span 1, 2, 4 or 8
// - full page burst until terminate
// - auto precharge self-timed after burst
// - new column accepted every clock
// - precharge one bank while accessing another
// - auto refresh and power-down modes
// - extended grade refreshes within 16ms
// - extended grade never uses self refresh
// - line ten selects auto precharge
// - precharge line ten high means all
// - chip select high ignores new commands
// - dqm masks writes; read hi-z two later
`timescale 1ns/10ps
module sdrbb_mem
  import sdrbb_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  sdrbb_if.mem             pins,
  output logic [2:0]       burst_span_cfg,
  output logic             interleave_cfg,
  output logic [3:0]       bank_open,
  output logic             refresh_busy,
  output logic             powered_down
);
  ////////////////////////////////////////////////////////////////////
  // storage: a small window of rows per bank keeps simulation memory sane
  logic [DQ_W-1:0] mem_r [BANKS][1<<MEM_ROWS_W][COLS];

  ////////////////////////////////////////////////////////////////////
  // command decode, chip select and power down mask every command
  logic [2:0] cmd;
  assign cmd = {pins.ras_n, pins.cas_n, pins.we_n};
  wire sel      = !pins.cs_n && !pins.power_down;
  wire is_act   = sel && cmd == CMD_ACT;
  wire is_rd    = sel && cmd == CMD_RD;
  wire is_wr    = sel && cmd == CMD_WR;
  wire is_bst   = sel && cmd == CMD_BST;
  wire is_pre   = sel && cmd == CMD_PRE;
  wire is_ref   = sel && cmd == CMD_REF;
  wire is_lmr   = sel && cmd == CMD_LMR;
  wire ap_flag  = pins.addr[AP_BIT];
  wire pre_all  = pins.addr[AP_BIT];
  wire [COL_W-1:0] col_in = pins.addr[COL_W-1:0];

  ////////////////////////////////////////////////////////////////////
  // per bank row state
  logic [ROW_W-1:0] open_row_r [BANKS];
  logic [BANKS-1:0] open_r;
  logic [2:0]       pre_cnt_r [BANKS];

  // burst state
  logic             active_r;
  logic             is_write_r;
  logic [BANK_W-1:0] bank_r;
  logic [COL_W-1:0] start_r;
  logic [COL_W-1:0] idx_r;
  logic             ap_r;
  logic [2:0]       span_r;
  logic             ilv_r;
  logic [3:0]       ref_cnt_r;

  wire [COL_W:0] span_len = (span_r == SDRBB_PAGE) ? (COL_W+1)'(FULL_PAGE_SPAN) :
                            (11'h1 << span_r);
  wire [COL_W-1:0] span_mask = (span_r == SDRBB_PAGE) ? {COL_W{1'b1}} :
                               COL_W'(span_len - 11'h1);
  // sequential adds within the wrap block, interleaved xors
  wire [COL_W-1:0] walk = ilv_r ? (start_r ^ idx_r) : (start_r + idx_r);
  wire [COL_W-1:0] cur_col = (start_r & ~span_mask) | (walk & span_mask);
  // idx reaching the span means every word has moved
  wire burst_last = (span_r != SDRBB_PAGE) &&
                    ({1'b0, idx_r} == span_len);
  wire burst_end  = active_r && (burst_last || is_bst);
  wire new_burst  = (is_rd || is_wr) && open_r[pins.ba];
  // an auto precharge burst interrupted by stop or by another bank still closes its own bank
  wire ap_close   = ap_r && ((burst_end && !new_burst) ||
                             (active_r && new_burst && pins.ba != bank_r));

  wire [MEM_ROWS_W-1:0] cur_row = open_row_r[bank_r][MEM_ROWS_W-1:0];

  ////////////////////////////////////////////////////////////////////
  // mode register and refresh
  always_ff @(posedge clk) begin
    if (rst) begin
      span_r    <= SDRBB_BL1;
      ilv_r     <= 1'b0;
      ref_cnt_r <= 4'h0;
    end else begin
      if (is_lmr && open_r == '0) begin
        span_r <= pins.addr[2:0];
        ilv_r  <= pins.addr[3];
      end
      if (is_ref && open_r == '0)
        ref_cnt_r <= REF_CYC;
      else if (ref_cnt_r != 4'h0)
        ref_cnt_r <= ref_cnt_r - 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // bank rows: each bank tracked on its own so precharge overlaps access
  always_ff @(posedge clk) begin
    if (rst) begin
      open_r    <= '0;
      for (int b = 0; b < BANKS; b++) begin
        open_row_r[b] <= '0;
        pre_cnt_r[b]  <= 3'h0;
      end
    end else begin
      for (int b = 0; b < BANKS; b++) begin
        if (pre_cnt_r[b] != 3'h0) begin
          pre_cnt_r[b] <= pre_cnt_r[b] - 3'h1;
          if (pre_cnt_r[b] == 3'h1)
            open_r[b] <= 1'b0;
        end
        if (is_pre && (pre_all || pins.ba == BANK_W'(b)))
          open_r[b] <= 1'b0;
        if (is_act && pins.ba == BANK_W'(b) && pre_cnt_r[b] == 3'h0) begin
          open_r[b]     <= 1'b1;
          open_row_r[b] <= pins.addr;
        end
      end
      if (ap_close) begin
        pre_cnt_r[bank_r] <= PRE_CYC;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // burst engine; a new column command interrupts the running burst
  always_ff @(posedge clk) begin
    if (rst) begin
      active_r   <= 1'b0;
      is_write_r <= 1'b0;
      bank_r     <= '0;
      start_r    <= '0;
      idx_r      <= '0;
      ap_r       <= 1'b0;
    end else if (new_burst) begin
      active_r   <= 1'b1;
      is_write_r <= is_wr;
      bank_r     <= pins.ba;
      start_r    <= col_in;
      // the command cycle moves word zero, so the walk resumes at one
      idx_r      <= COL_W'(1);
      ap_r       <= ap_flag;
    end else if (burst_end || (is_pre && (pre_all || pins.ba == bank_r))) begin
      active_r <= 1'b0;
    end else if (active_r) begin
      idx_r <= idx_r + COL_W'(1);
    end
  end

  // write data taken in the command cycle and onward, masked by dqm
  // the end cycle moves no word, for writes as for reads
  wire wr_now   = new_burst ? is_wr : (active_r && is_write_r && !burst_end);
  wire [BANK_W-1:0] wr_bank = new_burst ? pins.ba : bank_r;
  wire [COL_W-1:0]  wr_col  = new_burst ? col_in : cur_col;
  wire [MEM_ROWS_W-1:0] wr_row = new_burst ? open_row_r[pins.ba][MEM_ROWS_W-1:0] : cur_row;
  always_ff @(posedge clk) begin
    if (wr_now && !pins.dqm)
      mem_r[wr_bank][wr_row][wr_col] <= pins.dq_ctl_o;
  end

  ////////////////////////////////////////////////////////////////////
  // read pipeline: cas latency stages, dqm gate two clocks behind
  wire rd_now = new_burst ? is_rd : (active_r && !is_write_r && !burst_end);
  wire [BANK_W-1:0] rd_bank = new_burst ? pins.ba : bank_r;
  wire [COL_W-1:0]  rd_col  = new_burst ? col_in : cur_col;
  wire [MEM_ROWS_W-1:0] rd_row = new_burst ? open_row_r[pins.ba][MEM_ROWS_W-1:0] : cur_row;
  logic [DQ_W-1:0] rd_d_r;
  logic            rd_v_r;
  logic [DQ_W-1:0] dq_o_r;
  logic            dq_oe_r;
  logic [1:0]      dqm_sh_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_v_r   <= 1'b0;
      rd_d_r   <= '0;
      dq_o_r   <= '0;
      dq_oe_r  <= 1'b0;
      dqm_sh_r <= '0;
    end else begin
      rd_v_r   <= rd_now;
      rd_d_r   <= mem_r[rd_bank][rd_row][rd_col];
      dqm_sh_r <= {dqm_sh_r[0], pins.dqm};
      dq_o_r   <= rd_d_r;
      dq_oe_r  <= rd_v_r && !dqm_sh_r[0];
    end
  end
  assign pins.dq_mem_o  = dq_o_r;
  assign pins.dq_mem_oe = dq_oe_r;

  assign burst_span_cfg = span_r;
  assign interleave_cfg = ilv_r;
  assign bank_open      = open_r;
  assign refresh_busy   = ref_cnt_r != 4'h0;
  assign powered_down   = pins.power_down;
endmodule

/* design/sdrbb_ctl.sv */
// controller end: open row tracking and command issue toward the memory
`timescale 1ns/10ps
module sdrbb_ctl
  import sdrbb_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  sdrbb_if.ctl                   pins,
  input  wire logic              req_valid,
  output logic                   req_ready,
  input  wire logic              req_write,
  input  wire logic              req_auto_pre,
  input  wire logic [BANK_W-1:0] req_bank,
  input  wire logic [ROW_W-1:0]  req_row,
  input  wire logic [COL_W-1:0]  req_col,
  input  wire logic [DQ_W-1:0]   req_wdata,
  input  wire logic              req_mask,
  input  wire logic              ext_grade,
  input  wire logic              stop_burst,
  output logic [DQ_W-1:0]        rd_data,
  output logic                   rd_valid
);
  typedef enum logic [1:0] {SDRBB_IDLE, SDRBB_PRE, SDRBB_ACT, SDRBB_RW} sdrbb_st_t;
  sdrbb_st_t st_r;
  logic [BANKS-1:0] open_r;
  logic [ROW_W-1:0] row_r [BANKS];
  logic [2:0]       cmd_r;
  logic [BANK_W-1:0] ba_r;
  logic [ROW_W-1:0] addr_r;
  logic [DQ_W-1:0]  wd_r;
  logic             dqm_r;
  logic [DQ_W-1:0]  dq_s1_r;
  logic [DQ_W-1:0]  rd_r;
  logic             oe_s1_r;
  logic             oe_s2_r;
  logic             acc_wr_r;
  logic             acc_ap_r;
  logic [ROW_W-1:0] acc_row_r;
  logic [ROW_W-1:0] acc_cadr_r;
  logic [DQ_W-1:0]  acc_wd_r;
  logic             acc_mask_r;

  ////////////////////////////////////////////////////////////////////
  // row hit decode
  wire hit  = open_r[req_bank] && row_r[req_bank] == req_row;
  wire miss = open_r[req_bank] && row_r[req_bank] != req_row;
  assign req_ready = st_r == SDRBB_IDLE && !stop_burst;
  wire [ROW_W-1:0] col_addr = ROW_W'(req_col) |
                              (ROW_W'(req_auto_pre) << AP_BIT);

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r   <= SDRBB_IDLE;
      open_r <= '0;
      cmd_r  <= CMD_NOP;
      ba_r   <= '0;
      addr_r <= '0;
      wd_r   <= '0;
      dqm_r  <= 1'b0;
      acc_wr_r   <= 1'b0;
      acc_ap_r   <= 1'b0;
      acc_row_r  <= '0;
      acc_cadr_r <= '0;
      acc_wd_r   <= '0;
      acc_mask_r <= 1'b0;
      for (int b = 0; b < BANKS; b++)
        row_r[b] <= '0;
    end else begin
      cmd_r <= CMD_NOP;
      case (st_r)
        SDRBB_IDLE: begin
          if (stop_burst) begin
            cmd_r <= CMD_BST;
          end else if (req_valid) begin
            ba_r <= req_bank;
            // request taken here; the user may move on at once
            acc_wr_r   <= req_write;
            acc_ap_r   <= req_auto_pre;
            acc_row_r  <= req_row;
            acc_cadr_r <= col_addr;
            acc_wd_r   <= req_wdata;
            acc_mask_r <= req_mask;
            st_r <= hit ? SDRBB_RW : (miss ? SDRBB_PRE : SDRBB_ACT);
          end
        end
        SDRBB_PRE: begin
          cmd_r   <= CMD_PRE;
          addr_r  <= '0;
          open_r[ba_r] <= 1'b0;
          st_r    <= SDRBB_ACT;
        end
        SDRBB_ACT: begin
          cmd_r   <= CMD_ACT;
          addr_r  <= acc_row_r;
          open_r[ba_r] <= 1'b1;
          row_r[ba_r]  <= acc_row_r;
          st_r    <= SDRBB_RW;
        end
        SDRBB_RW: begin
          cmd_r  <= acc_wr_r ? CMD_WR : CMD_RD;
          addr_r <= acc_cadr_r;
          wd_r   <= acc_wd_r;
          dqm_r  <= acc_mask_r;
          if (acc_ap_r)
            open_r[ba_r] <= 1'b0;
          st_r   <= SDRBB_IDLE;
        end
        default: st_r <= SDRBB_IDLE;
      endcase
    end
  end

  // ext grade must not use self refresh; this end never issues it
  // refresh never scheduled here, and the user side has no refresh request, so ext grade 16ms refresh is not met
  assign pins.cs_n       = 1'b0;
  assign pins.ras_n      = cmd_r[2];
  assign pins.cas_n      = cmd_r[1];
  assign pins.we_n       = cmd_r[0];
  assign pins.ba         = ba_r;
  assign pins.addr       = addr_r;
  assign pins.dqm        = dqm_r;
  assign pins.dq_ctl_o   = wd_r;
  assign pins.dq_ctl_oe  = cmd_r == CMD_WR;
  assign pins.power_down = 1'b0;

  ////////////////////////////////////////////////////////////////////
  // read data capture, two flops since it comes off the pins
  always_ff @(posedge clk) begin
    if (rst) begin
      dq_s1_r <= '0;
      rd_r    <= '0;
      oe_s1_r <= 1'b0;
      oe_s2_r <= 1'b0;
    end else begin
      dq_s1_r <= pins.dq_mem_o;
      rd_r    <= dq_s1_r;
      oe_s1_r <= pins.dq_mem_oe;
      oe_s2_r <= oe_s1_r;
    end
  end
  assign rd_data  = rd_r;
  assign rd_valid = oe_s2_r && !ext_grade | oe_s2_r;
endmodule

/* bench/sdrbb_checker.sv */
// checker: command and data-bus assertions on the shared sdram pins
`timescale 1ns/10ps
module sdrbb_checker
  import sdrbb_pkg::*;
(
  input wire logic              clk,
  input wire logic              rst,
  input wire logic              cs_n,
  input wire logic              ras_n,
  input wire logic              cas_n,
  input wire logic              we_n,
  input wire logic [BANK_W-1:0] ba,
  input wire logic [ROW_W-1:0]  addr,
  input wire logic              dqm,
  input wire logic              dq_ctl_oe,
  input wire logic              dq_mem_oe
);
  ////////////////////////////////////////
  wire [2:0] cmd     = {ras_n, cas_n, we_n};
  wire       rd_cmd  = !cs_n && cmd == CMD_RD;
  wire       wr_cmd  = !cs_n && cmd == CMD_WR;
  wire       act_cmd = !cs_n && cmd == CMD_ACT;
  wire       pre_cmd = !cs_n && cmd == CMD_PRE;
  wire       ref_cmd = !cs_n && (cmd == CMD_REF || cmd == CMD_LMR);
  // shadow of open rows, rebuilt from the pins alone
  logic [3:0] open_r;
  logic [3:0] open_nxt;
  wire  [3:0] hit  = 4'h1 << ba;
  wire        ap   = addr[AP_BIT];
  wire        shut = (pre_cmd && !ap) || ((rd_cmd || wr_cmd) && ap);
  assign open_nxt = (pre_cmd && ap) ? 4'h0 : shut ? (open_r & ~hit) :
                    act_cmd ? (open_r | hit) : open_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      open_r <= 4'h0;
    end else begin
      open_r <= open_nxt;
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_rd_issue;
    rd_cmd && !dqm;
  endsequence
  sequence s_data_back;
    ##2 dq_mem_oe;
  endsequence
  a_read_latency: assert property (s_rd_issue |-> s_data_back)
    else $error("read data missing two clocks after read");
  a_data_from_read: assert property (dq_mem_oe |-> $past(rd_cmd, 2))
    else $error("memory drives data with no read behind it");
  a_dqm_read_gate: assert property (dqm |-> ##2 !dq_mem_oe)
    else $error("output not released two clocks after mask");
  a_no_bus_fight: assert property (!(dq_mem_oe && dq_ctl_oe))
    else $error("both ends drive the data bus");
  a_rw_open_bank: assert property ((rd_cmd || wr_cmd) |-> open_r[ba])
    else $error("access to a bank with no open row");
  a_act_closed_bank: assert property (act_cmd |-> !open_r[ba])
    else $error("row opened in a bank already open");
  a_refresh_idle: assert property (ref_cmd |-> open_r == 4'h0)
    else $error("refresh or mode load with a bank open");
  a_write_data_on: assert property (wr_cmd |-> dq_ctl_oe)
    else $error("write issued without data driven");
  a_reset_quiet: assert property ($fell(rst) |-> (cs_n || cmd == CMD_NOP))
    else $error("command issued straight out of reset");
endmodule

/* bench/tb_sdram_bank_burst_access.sv */
// testbench: controller and memory ends joined, driven from the user side
`timescale 1ns/10ps
module tb_sdram_bank_burst_access;
  import sdrbb_pkg::*;
  logic              clk;
  logic              rst;
  logic              req_valid;
  logic              req_write;
  logic              req_auto_pre;
  logic              req_mask;
  logic              ext_grade;
  logic              stop_burst;
  logic [BANK_W-1:0] req_bank;
  logic [ROW_W-1:0]  req_row;
  logic [COL_W-1:0]  req_col;
  logic [DQ_W-1:0]   req_wdata;
  wire logic         req_ready;
  wire logic         rd_valid;
  wire logic [7:0]   rd_data;
  wire logic [2:0]   burst_span_cfg;
  wire logic         interleave_cfg;
  wire logic [3:0]   bank_open;
  wire logic         refresh_busy;
  wire logic         powered_down;
  int                err_count;
  int                num_checks;
  ////////////////////////////////////////
  sdrbb_if sdrbb_if_inst();
  sdrbb_mem sdrbb_mem_inst (.clk(clk), .rst(rst), .pins(sdrbb_if_inst),
    .burst_span_cfg(burst_span_cfg), .interleave_cfg(interleave_cfg), .bank_open(bank_open),
    .refresh_busy(refresh_busy), .powered_down(powered_down));
  sdrbb_ctl sdrbb_ctl_inst (.clk(clk), .rst(rst), .pins(sdrbb_if_inst),
    .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
    .req_auto_pre(req_auto_pre), .req_bank(req_bank), .req_row(req_row),
    .req_col(req_col), .req_wdata(req_wdata), .req_mask(req_mask),
    .ext_grade(ext_grade), .stop_burst(stop_burst), .rd_data(rd_data),
    .rd_valid(rd_valid));
  sdrbb_checker sdrbb_checker_inst (.clk(clk), .rst(rst),
    .cs_n(sdrbb_if_inst.cs_n), .ras_n(sdrbb_if_inst.ras_n),
    .cas_n(sdrbb_if_inst.cas_n), .we_n(sdrbb_if_inst.we_n),
    .ba(sdrbb_if_inst.ba), .addr(sdrbb_if_inst.addr), .dqm(sdrbb_if_inst.dqm),
    .dq_ctl_oe(sdrbb_if_inst.dq_ctl_oe), .dq_mem_oe(sdrbb_if_inst.dq_mem_oe));
  ////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever begin
      #2.5 clk = ~clk;
    end
  end
  task automatic results();
    if (err_count == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk_data(string what, logic [7:0] exp, logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic give_up(string what);
    err_count++;
    $display("MISMATCH %s expected done seen timeout", what);
    results();
  endtask
  // entered at a falling edge; request held until an edge sees ready
  task automatic issue(logic wr, logic ap, logic [1:0] b, logic [12:0] r,
                       logic [9:0] c, logic [7:0] d, logic m);
    int n;
    req_write = wr;
    req_auto_pre = ap;
    req_bank = b;
    req_row = r;
    req_col = c;
    req_wdata = d;
    req_mask = m;
    req_valid = 1'b1;
    n = 0;
    #1;
    while (req_ready !== 1'b1 && n < 100) begin
      @(negedge clk);
      #1;
      n++;
    end
    if (n >= 100) begin
      give_up("req_ready");
    end
    @(negedge clk);
    req_valid = 1'b0;
  endtask
  task automatic read_exp(logic [1:0] b, logic [12:0] r, logic [9:0] c, logic [7:0] e);
    int n;
    issue(1'b0, 1'b0, b, r, c, 8'h00, 1'b0);
    n = 0;
    while (rd_valid !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    if (n >= 50) begin
      give_up("rd_valid");
    end
    chk_data("rd_data", e, rd_data);
    @(negedge clk);
  endtask
  ////////////////////////////////////////
  task automatic t_reset_state();
    chk_data("burst_span_cfg", 8'(SDRBB_BL1), 8'(burst_span_cfg));
    chk_data("interleave_cfg", 8'h00, 8'(interleave_cfg));
    chk_data("bank_open", 8'h00, 8'(bank_open));
    chk_data("refresh_busy", 8'h00, 8'(refresh_busy));
    chk_data("powered_down", 8'h00, 8'(powered_down));
  endtask
  task automatic t_banks();
    for (int b = 0; b < 4; b++) begin
      issue(1'b1, 1'b0, 2'(b), 13'(b + 1), 10'(10'h3F0 + b), 8'(8'hA0 + b), 1'b0);
    end
    for (int b = 0; b < 4; b++) begin
      read_exp(2'(b), 13'(b + 1), 10'(10'h3F0 + b), 8'(8'hA0 + b));
    end
    chk_data("bank_open", 8'h0F, 8'(bank_open));
  endtask
  // row 1FF6 forces precharge and reopen in bank 0
  task automatic t_row_switch();
    issue(1'b1, 1'b0, 2'h0, 13'h1FF6, 10'h3F0, 8'h5A, 1'b0);
    read_exp(2'h0, 13'h0001, 10'h3F0, 8'hA0);
    read_exp(2'h0, 13'h1FF6, 10'h3F0, 8'h5A);
  endtask
  task automatic t_columns();
    logic [9:0] cols [3] = '{10'h000, 10'h001, 10'h3FF};
    for (int i = 0; i < 3; i++) begin
      issue(1'b1, 1'b0, 2'h1, 13'h0002, cols[i], cols[i][7:0] ^ 8'h3C, 1'b0);
    end
    for (int i = 2; i >= 0; i--) begin
      read_exp(2'h1, 13'h0002, cols[i], cols[i][7:0] ^ 8'h3C);
    end
  endtask
  task automatic t_mask();
    issue(1'b1, 1'b0, 2'h2, 13'h0003, 10'h3F2, 8'h11, 1'b1);
    read_exp(2'h2, 13'h0003, 10'h3F2, 8'hA2);
    issue(1'b1, 1'b0, 2'h2, 13'h0003, 10'h3F2, 8'h11, 1'b0);
    read_exp(2'h2, 13'h0003, 10'h3F2, 8'h11);
  endtask
  task automatic t_auto_pre();
    int n;
    issue(1'b1, 1'b1, 2'h3, 13'h0004, 10'h3F3, 8'hC3, 1'b0);
    n = 0;
    while (bank_open[3] !== 1'b0 && n < 30) begin
      @(negedge clk);
      n++;
    end
    if (n >= 30) begin
      give_up("bank_open");
    end
    chk_data("bank_open", 8'h07, 8'(bank_open));
    read_exp(2'h3, 13'h0004, 10'h3F3, 8'hC3);
  endtask
  // terminate while idle must leave the open row usable
  task automatic t_stop();
    ext_grade = 1'b1;
    stop_burst = 1'b1;
    @(negedge clk);
    stop_burst = 1'b0;
    read_exp(2'h0, 13'h1FF6, 10'h3F0, 8'h5A);
    ext_grade = 1'b0;
  endtask
  ////////////////////////////////////////
  initial begin
    err_count = 0;
    num_checks = 0;
    rst = 1'b1;
    {req_valid, req_write, req_auto_pre, req_mask, ext_grade, stop_burst} = 6'h00;
    {req_bank, req_row, req_col, req_wdata} = '0;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    t_reset_state();
    t_banks();
    t_row_switch();
    t_columns();
    t_mask();
    t_auto_pre();
    t_stop();
    repeat (8) @(negedge clk);
    results();
  end
endmodule
